// ### logic/bormc_pkg.sv
package bormc_pkg;

  // clock rate and timing figures
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned POWERUP_DELAY_TIMER_TIME_MS = 64;
  localparam int unsigned POWERUP_DELAY_TIMER_CYC     = POWERUP_DELAY_TIMER_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned FILT_TIME_NS = 1000;
  localparam int unsigned FILT_CYC     = (FILT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DLY_FOSC     = 10;
  localparam int unsigned DLY_CYC      = DLY_FOSC;
  localparam int unsigned SEQ_W        = 23;
  localparam int unsigned FILT_W       = 8;

  // register map
  localparam int unsigned ADDR_W   = 4;
  localparam logic [3:0]  OFS_CFG  = 4'h0;
  localparam logic [3:0]  OFS_CTL  = 4'h4;
  localparam logic [3:0]  OFS_STAT = 4'h8;
  localparam logic [3:0]  OFS_SEQ  = 4'hC;

  // control register bits
  localparam int unsigned CTL_SWEN_B = 0;
  localparam int unsigned CTL_RDY_B  = 1;
  localparam logic        SWEN_RST   = 1'h1;

  // status register bits
  localparam int unsigned STAT_W    = 8;
  localparam int unsigned STB_POR   = 0;
  localparam int unsigned STB_BOR   = 1;
  localparam int unsigned STB_MCLR  = 2;
  localparam int unsigned STB_WDT   = 3;
  localparam int unsigned STB_RI    = 4;
  localparam int unsigned STB_SOVF  = 5;
  localparam int unsigned STB_SUNF  = 6;
  localparam int unsigned STB_PEXIT = 7;
  localparam logic [7:0]  STAT_INV  = 8'h1F;
  localparam logic [7:0]  STAT_RST  = 8'h01;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_SW    = 2'b01,
    MODE_NOSLP = 2'b10,
    MODE_ON    = 2'b11
  } bormc_mode_t;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b000,
    ST_POWERUP_DELAY_TIMER  = 3'b001,
    ST_MCLR  = 3'b010,
    ST_DLY   = 3'b011,
    ST_GATE  = 3'b100,
    ST_RUN   = 3'b101,
    ST_SLEEP = 3'b110,
    ST_WAKE  = 3'b111
  } bormc_state_t;

  typedef struct packed {
    logic        lp_drop_en;
    logic        mclr_en;
    logic        powerup_delay_enable_n;
    logic        brownout_level_sel;
    bormc_mode_t brownout_mode_sel;
  } bormc_cfg_t;

  localparam int unsigned CFG_W   = $bits(bormc_cfg_t);
  localparam logic [5:0]  CFG_RST = 6'h1F;

  // analog comparator and pin levels, asynchronous
  typedef struct packed {
    logic por_low;
    logic bo_low_hi;
    logic bo_low_lo;
    logic lp_drop_low;
    logic bo_ready;
    logic mclr_n;
  } bormc_ana_t;

  // synchroniser start values, the pin idles high so no false pin reset
  localparam logic [5:0]  ANA_RST = 6'h01;

  // same-clock reset request pulses
  typedef struct packed {
    logic wdt_rst;
    logic reset_instr;
    logic stack_ovf;
    logic stack_unf;
    logic prog_exit;
  } bormc_evt_t;

endpackage

// ### logic/bormc_sync.sv
`timescale 1ns/1ps
module bormc_sync #(
  parameter int           W       = 6,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // two flops per bit, first stage feeds only the second
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    logic meta_nxt;
    logic sync_nxt;
    always_comb begin
      meta_nxt = din[i];
      sync_nxt = meta_r[i];
    end
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        meta_r[i] <= RST_VAL[i];
        sync_r[i] <= RST_VAL[i];
      end else if (ce) begin
        meta_r[i] <= meta_nxt;
        sync_r[i] <= sync_nxt;
      end
    end
  end

  assign dout = sync_r;

endmodule

// ### logic/bormc_counter.sv
`timescale 1ns/1ps
module bormc_counter #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic [W-1:0] limit,
  output logic      [W-1:0] count,
  output logic              done
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // count up from clear, park at the limit
  always_comb begin
    cnt_nxt = cnt_r;
    if (clr)
      cnt_nxt = '0;
    else if (!done)
      cnt_nxt = cnt_r + 1'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      cnt_r <= '0;
    else if (ce)
      cnt_r <= cnt_nxt;
  end

  assign done  = (cnt_r >= limit);
  assign count = cnt_r;

endmodule

// ### logic/bormc_top.sv
`timescale 1ns/1ps
module bormc_top #(
  parameter int unsigned POWERUP_DELAY_TIMER_CYC = bormc_pkg::POWERUP_DELAY_TIMER_CYC
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  wire bormc_pkg::bormc_ana_t         ana,
  input  wire bormc_pkg::bormc_evt_t         evt,
  input  wire logic                          sleep_req,
  input  wire logic                          wake_req,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [bormc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               core_reset,
  output logic                               core_run,
  output logic                               bo_enable,
  output logic                               brownout_ready
);

  bormc_pkg::bormc_ana_t   as;
  bormc_pkg::bormc_cfg_t   cfg_r, cfg_nxt;
  bormc_pkg::bormc_state_t state_r, state_nxt;
  bormc_pkg::bormc_mode_t  mode;
  logic                         sw_en_r, sw_en_nxt;
  logic [bormc_pkg::STAT_W-1:0] occ_r, occ_nxt, ev_vec, w1c;
  logic                         cause_pb_r, cause_pb_nxt;
  logic                         mclr_seen_r, mclr_seen_nxt;
  logic                         core_reset_r, core_reset_nxt;
  logic                         core_run_r, core_run_nxt;
  logic                         bo_en_r, rdy_r;
  logic [31:0]                  prdata_r, prdata_nxt, rdata;
  logic                         unmapped, wr;
  logic                         bor_act, bor_low, bor_rdy, ok_supply, sw_force;
  logic                         bor_trip, lp_trip, bor_gen, mclr_low, evt_any, hold_any;
  logic                         need_powerup_delay_timer, start_wait, wake_wait, filt_clr, filt_done;
  logic                         seq_clr, seq_done;
  logic [bormc_pkg::FILT_W-1:0] filt_cnt;
  logic [bormc_pkg::SEQ_W-1:0]  seq_cnt, seq_lim;

  // comparator levels and the pin into the clock domain
  bormc_sync #(
    .W       ($bits(bormc_pkg::bormc_ana_t)),
    .RST_VAL (bormc_pkg::ANA_RST)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .din     (ana),
    .dout    (as)
  );

  // supply-low filter
  bormc_counter #(
    .W (bormc_pkg::FILT_W)
  ) u_filt (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .clr     (filt_clr),
    .limit   (bormc_pkg::FILT_W'(bormc_pkg::FILT_CYC)),
    .count   (filt_cnt),
    .done    (filt_done)
  );

  // power-up timer and post-pin delay share one counter
  bormc_counter #(
    .W (bormc_pkg::SEQ_W)
  ) u_seq (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .clr     (seq_clr),
    .limit   (seq_lim),
    .count   (seq_cnt),
    .done    (seq_done)
  );

  // protection enable per mode
  always_comb begin
    mode     = cfg_r.brownout_mode_sel;
    sw_force = (mode == bormc_pkg::MODE_SW) && cause_pb_r && (state_r == bormc_pkg::ST_WAKE);
    case (mode)
      bormc_pkg::MODE_ON:    bor_act = 1'h1;
      bormc_pkg::MODE_NOSLP: bor_act = (state_r != bormc_pkg::ST_SLEEP);
      bormc_pkg::MODE_SW:    bor_act = sw_en_r || sw_force;
      default:               bor_act = 1'h0;
    endcase
  end

  // trip detection and request merge
  always_comb begin
    bor_low   = cfg_r.brownout_level_sel ? as.bo_low_lo : as.bo_low_hi;
    bor_rdy   = bor_act && as.bo_ready;
    ok_supply = bor_rdy && !bor_low;
    filt_clr  = !(bor_act && bor_low);
    bor_trip  = filt_done && !filt_clr;
    lp_trip   = cfg_r.lp_drop_en && as.lp_drop_low;
    bor_gen   = bor_trip || lp_trip;
    mclr_low  = cfg_r.mclr_en && !as.mclr_n;
    evt_any   = |evt;
    hold_any  = as.por_low || bor_gen || evt_any;
    need_powerup_delay_timer = cause_pb_r && !cfg_r.powerup_delay_enable_n;
  end

  // start and wake gating
  always_comb begin
    case (mode)
      bormc_pkg::MODE_ON:    start_wait = !ok_supply;
      bormc_pkg::MODE_NOSLP: start_wait = !ok_supply;
      bormc_pkg::MODE_SW:    start_wait = sw_en_r && !ok_supply;
      default:               start_wait = 1'h0;
    endcase
    case (mode)
      bormc_pkg::MODE_ON:    wake_wait = 1'h0;
      bormc_pkg::MODE_NOSLP: wake_wait = !ok_supply;
      bormc_pkg::MODE_SW:    wake_wait = (sw_en_r || cause_pb_r) && !ok_supply;
      default:               wake_wait = 1'h0;
    endcase
  end

  // reset and start sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bormc_pkg::ST_HOLD:
        state_nxt = need_powerup_delay_timer ? bormc_pkg::ST_POWERUP_DELAY_TIMER : bormc_pkg::ST_MCLR;
      bormc_pkg::ST_POWERUP_DELAY_TIMER:
        if (seq_done)
          state_nxt = bormc_pkg::ST_MCLR;
      bormc_pkg::ST_MCLR:
        if (!mclr_low)
          state_nxt = mclr_seen_r ? bormc_pkg::ST_DLY : bormc_pkg::ST_GATE;
      bormc_pkg::ST_DLY:
        if (seq_done)
          state_nxt = bormc_pkg::ST_GATE;
      bormc_pkg::ST_GATE:
        if (!start_wait)
          state_nxt = bormc_pkg::ST_RUN;
      bormc_pkg::ST_RUN:
        if (sleep_req)
          state_nxt = bormc_pkg::ST_SLEEP;
      bormc_pkg::ST_SLEEP:
        if (wake_req)
          state_nxt = bormc_pkg::ST_WAKE;
      default:
        if (!wake_wait)
          state_nxt = bormc_pkg::ST_RUN;
    endcase
    // the timer keeps running while the pin alone is low
    if (hold_any)
      state_nxt = bormc_pkg::ST_HOLD;
    else if (mclr_low && (state_r > bormc_pkg::ST_MCLR))
      state_nxt = bormc_pkg::ST_HOLD;
    seq_clr        = (state_nxt != state_r);
    seq_lim        = (state_r == bormc_pkg::ST_POWERUP_DELAY_TIMER) ? bormc_pkg::SEQ_W'(POWERUP_DELAY_TIMER_CYC - 1)
                                                     : bormc_pkg::SEQ_W'(bormc_pkg::DLY_CYC - 1);
    mclr_seen_nxt  = mclr_low || (mclr_seen_r && (state_r != bormc_pkg::ST_GATE));
    cause_pb_nxt   = cause_pb_r;
    if (as.por_low || bor_gen)
      cause_pb_nxt = 1'h1;
    else if (evt_any || mclr_low)
      cause_pb_nxt = 1'h0;
    core_reset_nxt = (state_nxt <= bormc_pkg::ST_DLY);
    core_run_nxt   = (state_nxt == bormc_pkg::ST_RUN);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r      <= bormc_pkg::ST_HOLD;
      mclr_seen_r  <= 1'h0;
      cause_pb_r   <= 1'h1;
      core_reset_r <= 1'h1;
      core_run_r   <= 1'h0;
      bo_en_r      <= 1'h0;
      rdy_r        <= 1'h0;
    end else if (ce) begin
      state_r      <= state_nxt;
      mclr_seen_r  <= mclr_seen_nxt;
      cause_pb_r   <= cause_pb_nxt;
      core_reset_r <= core_reset_nxt;
      core_run_r   <= core_run_nxt;
      bo_en_r      <= bor_act;
      rdy_r        <= bor_rdy;
    end
  end

  // register read decode and write strobes
  always_comb begin
    unmapped = 1'h0;
    rdata    = '0;
    if (paddr == bormc_pkg::OFS_CFG)
      rdata = 32'(cfg_r);
    else if (paddr == bormc_pkg::OFS_CTL) begin
      rdata[bormc_pkg::CTL_SWEN_B] = sw_en_r;
      rdata[bormc_pkg::CTL_RDY_B]  = rdy_r;
    end else if (paddr == bormc_pkg::OFS_STAT)
      rdata = 32'(occ_r ^ bormc_pkg::STAT_INV);
    else if (paddr == bormc_pkg::OFS_SEQ)
      rdata = 32'({state_r, core_run_r, core_reset_r});
    else
      unmapped = 1'h1;
    wr         = psel && penable && pwrite && ce && !unmapped;
    prdata_nxt = (psel && !penable) ? rdata : prdata_r;
    cfg_nxt    = cfg_r;
    sw_en_nxt  = sw_en_r;
    w1c        = '0;
    if (wr && (paddr == bormc_pkg::OFS_CFG))
      cfg_nxt = bormc_pkg::bormc_cfg_t'(pwdata[bormc_pkg::CFG_W-1:0]);
    if (wr && (paddr == bormc_pkg::OFS_CTL))
      sw_en_nxt = pwdata[bormc_pkg::CTL_SWEN_B];
    if (wr && (paddr == bormc_pkg::OFS_STAT))
      w1c = pwdata[bormc_pkg::STAT_W-1:0];
  end

  // reset cause flags, a new event wins over a rearm write
  always_comb begin
    ev_vec                       = '0;
    ev_vec[bormc_pkg::STB_POR]   = as.por_low;
    ev_vec[bormc_pkg::STB_BOR]   = bor_gen;
    ev_vec[bormc_pkg::STB_MCLR]  = mclr_low;
    ev_vec[bormc_pkg::STB_WDT]   = evt.wdt_rst;
    ev_vec[bormc_pkg::STB_RI]    = evt.reset_instr;
    ev_vec[bormc_pkg::STB_SOVF]  = evt.stack_ovf;
    ev_vec[bormc_pkg::STB_SUNF]  = evt.stack_unf;
    ev_vec[bormc_pkg::STB_PEXIT] = evt.prog_exit;
    occ_nxt                      = (occ_r & ~w1c) | ev_vec;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_r    <= bormc_pkg::bormc_cfg_t'(bormc_pkg::CFG_RST);
      sw_en_r  <= bormc_pkg::SWEN_RST;
      occ_r    <= bormc_pkg::STAT_RST;
      prdata_r <= '0;
    end else if (ce) begin
      cfg_r    <= cfg_nxt;
      sw_en_r  <= sw_en_nxt;
      occ_r    <= occ_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // outputs
  assign prdata         = prdata_r;
  assign pready         = ce;
  assign pslverr        = psel && penable && unmapped;
  assign core_reset     = core_reset_r;
  assign core_run       = core_run_r;
  assign bo_enable      = bo_en_r;
  assign brownout_ready = rdy_r;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !ce);

  sequence s_wake_start;
    state_r == bormc_pkg::ST_SLEEP ##1 state_r == bormc_pkg::ST_WAKE;
  endsequence

  sequence s_dly_exit;
    state_r == bormc_pkg::ST_DLY ##1 state_r == bormc_pkg::ST_GATE;
  endsequence

  a_por_holds_core: assert property (as.por_low |=> core_reset_r && !core_run_r)
    else $error("core not held while supply below minimum");
  a_events_reset: assert property (evt_any |=> core_reset_r ##1 core_reset_r)
    else $error("reset request did not hold core");
  a_filter_min: assert property (filt_clr |=> !bor_trip)
    else $error("brown-out tripped without filter time");
  a_bor_flag: assert property (bor_gen |=> occ_r[bormc_pkg::STB_BOR] && core_reset_r)
    else $error("brown-out flag not recorded");
  a_start_waits_on: assert property (
      state_r == bormc_pkg::ST_GATE && mode == bormc_pkg::MODE_ON && !ok_supply
      |=> state_r != bormc_pkg::ST_RUN)
    else $error("start not delayed for ready");
  a_run_ready_set: assert property (
      $rose(core_run_r) && $past(state_r) == bormc_pkg::ST_GATE && mode == bormc_pkg::MODE_ON
      |-> $past(bor_rdy))
    else $error("core started before ready");
  a_wake_no_delay: assert property (
      s_wake_start ##0 (mode == bormc_pkg::MODE_ON && !hold_any && !mclr_low)
      |=> state_r == bormc_pkg::ST_RUN)
    else $error("wake delayed in always-on mode");
  a_sleep_prot_off: assert property (
      state_r == bormc_pkg::ST_SLEEP && mode == bormc_pkg::MODE_NOSLP |=> !bo_en_r)
    else $error("protection active in sleep");
  a_off_immediate: assert property (
      state_r == bormc_pkg::ST_GATE && mode == bormc_pkg::MODE_OFF && !hold_any && !mclr_low
      |=> state_r == bormc_pkg::ST_RUN ##0 core_run_r)
    else $error("start delayed in off mode");
  a_off_ignore_sw: assert property (mode == bormc_pkg::MODE_OFF |=> !bo_en_r || mode != bormc_pkg::MODE_OFF)
    else $error("software enable acted in off mode");
  a_dly_ten: assert property (s_dly_exit |-> $past(seq_cnt) == bormc_pkg::SEQ_W'(bormc_pkg::DLY_CYC - 1))
    else $error("pin release delay not ten cycles");
  a_powerup_delay_timer_held: assert property (
      state_r == bormc_pkg::ST_POWERUP_DELAY_TIMER && !seq_done |=> state_r inside {bormc_pkg::ST_POWERUP_DELAY_TIMER, bormc_pkg::ST_HOLD})
    else $error("power-up timer cut short");

endmodule

// ### tb/bormc_supply_model.sv
`timescale 1ns/1ps
module bormc_supply_model #(
  parameter int RDY_DLY = 30
) (
  input  wire logic             sys_clk,
  input  wire logic             bo_enable,
  input  wire logic [15:0]      vdd_mv,
  input  wire logic             lp_low,
  input  wire logic             pin_n,
  output bormc_pkg::bormc_ana_t ana
);
  int rdy_cnt = 0;

  // ready settles a while after the circuit is switched on, drops when off
  always @(posedge sys_clk) begin
    if (bo_enable !== 1'h1)
      rdy_cnt <= 0;
    else if (rdy_cnt < RDY_DLY)
      rdy_cnt <= rdy_cnt + 1;
  end

  // comparators: power-on point, then low and high brown-out trip points
  always_comb begin
    ana.por_low     = vdd_mv < 16'h05DC;
    ana.bo_low_lo   = vdd_mv < 16'h07D0;
    ana.bo_low_hi   = vdd_mv < 16'h09C4;
    ana.lp_drop_low = lp_low;
    ana.bo_ready    = (bo_enable === 1'h1) && (rdy_cnt >= RDY_DLY);
    ana.mclr_n      = pin_n;
  end
endmodule

// ### tb/brownout_reset_mode_control_tb_top.sv
`timescale 1ns/1ps
module brownout_reset_mode_control_tb_top;
  localparam int POWERUP_DELAY_TIMER = 20;
  localparam int RDY  = 30;

  logic                  sys_clk, rst_n, ce, sleep_req, wake_req;
  logic                  psel, penable, pwrite, pready, pslverr;
  logic [3:0]            paddr;
  logic [31:0]           pwdata, prdata, rd_data;
  logic                  core_reset, core_run, bo_enable, brownout_ready, rd_err;
  logic [15:0]           vdd_mv;
  logic                  lp_low, pin_n;
  bormc_pkg::bormc_evt_t evt;
  bormc_pkg::bormc_ana_t ana;
  int                    error_cnt = 0;
  int                    check_count = 0;
  int                    seed = 85583;
  int                    cnt, g;

  bormc_supply_model #(.RDY_DLY(RDY)) supply_u (.sys_clk(sys_clk), .bo_enable(bo_enable), .vdd_mv(vdd_mv),
    .lp_low(lp_low), .pin_n(pin_n), .ana(ana));

  bormc_top #(.POWERUP_DELAY_TIMER_CYC(POWERUP_DELAY_TIMER)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .ana(ana), .evt(evt),
    .sleep_req(sleep_req), .wake_req(wake_req), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_reset(core_reset), .core_run(core_run), .bo_enable(bo_enable), .brownout_ready(brownout_ready));

  // clock generator, 8 ns period
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  // expected protection state from mode, software enable and sleep
  function automatic logic exp_bo(input logic [1:0] m, input logic s, input logic asleep);
    case (m)
      2'h3: return 1'h1;
      2'h2: return !asleep;
      2'h1: return s;
      default: return 1'h0;
    endcase
  endfunction

  // status read value from the set of occurred causes
  function automatic logic [7:0] exp_stat(input logic [7:0] occ);
    return occ ^ bormc_pkg::STAT_INV;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one apb transfer, response taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [3:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge sys_clk);
    penable <= 1'h1;
    // no cycle limit here, the watchdog ends a hung access
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'h1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // cycles until the core runs, bounded
  task automatic wait_run(output int c);
    c = 0;
    while (core_run !== 1'h1 && c < 3000) begin
      @(negedge sys_clk);
      c++;
    end
    if (c >= 3000)
      check(core_run, 1'h1, "core never started");
  endtask

  // cycles until core reset reaches a level, bounded
  task automatic wait_rst(input logic lvl, output int c);
    c = 0;
    while (core_reset !== lvl && c < 3000) begin
      @(negedge sys_clk);
      c++;
    end
  endtask

  task automatic pulse_evt(input int i);
    @(posedge sys_clk);
    evt <= 5'h01 << i;
    @(posedge sys_clk);
    evt <= '0;
  endtask

  // watchdog against a hung sequence
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, sleep_req, wake_req, lp_low} = '0;
    ce     = 1'h1;
    evt    = '0;
    vdd_mv = 16'h0CE4;
    pin_n  = 1'h1;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'h1;
    wait_run(cnt);
    check(brownout_ready, 1'h1, "run before ready");
    check(core_reset, 1'h0, "reset while running");
    apb(1'h0, 4'h0, '0);
    check(rd_data[5:0], 6'h1F, "cfg reset");
    apb(1'h0, 4'h4, '0);
    check(rd_data[1:0], 2'h3, "ctl reset and ready");
    apb(1'h0, 4'h8, '0);
    check(rd_data[7:0], exp_stat(8'h01), "stat after power-on");
    apb(1'h1, 4'h2, 32'hFFFFFFFF);
    check(rd_err, 1'h1, "unmapped write error");
    check(rd_data, 32'h0, "unmapped write data");
    apb(1'h0, 4'h2, '0);
    check(rd_err, 1'h1, "unmapped read error");
    check(rd_data, 32'h0, "unmapped read data");
    // clock enable low freezes the sequencer, a sleep request is not taken
    @(posedge sys_clk);
    ce        <= 1'h0;
    sleep_req <= 1'h1;
    tick(20);
    check(core_run, 1'h1, "run lost while frozen");
    check(pready, 1'h0, "ready while frozen");
    @(posedge sys_clk);
    ce        <= 1'h1;
    sleep_req <= 1'h0;
    tick(4);
    check(core_run, 1'h1, "run lost after freeze");
    // level select: 2.2 V trips only the high point
    vdd_mv <= 16'h0898;
    tick(200);
    check(core_reset, 1'h0, "low point tripped");
    vdd_mv <= 16'h0A8C;
    apb(1'h1, 4'h0, 32'h1B);
    g = 10 + ($unsigned($random(seed)) % 100);
    vdd_mv <= 16'h0898;
    tick(g);
    vdd_mv <= 16'h0A8C;
    tick(20);
    check(core_reset, 1'h0, "glitch caused reset");
    @(posedge sys_clk);
    vdd_mv <= 16'h0898;
    wait_rst(1'h1, cnt);
    check(cnt >= 125 && cnt <= 135, 1'h1, "filter length");
    vdd_mv <= 16'h0CE4;
    wait_run(cnt);
    apb(1'h0, 4'h8, '0);
    check(rd_data[1], 1'h0, "brown-out flag");
    apb(1'h1, 4'h8, 32'h02);
    // low-power drop joins the brown-out cause
    apb(1'h1, 4'h0, 32'h3F);
    lp_low <= 1'h1;
    tick(8);
    check(core_reset, 1'h1, "low-power drop");
    lp_low <= 1'h0;
    wait_run(cnt);
    apb(1'h0, 4'h8, '0);
    check(rd_data[1], 1'h0, "low-power flag");
    apb(1'h1, 4'h8, 32'hFF);
    apb(1'h1, 4'h0, 32'h1F);
    // every same-clock reset source
    for (int i = 0; i < 5; i++) begin
      pulse_evt(i);
      tick(2);
      check(core_reset, 1'h1, "event reset");
      wait_run(cnt);
      apb(1'h0, 4'h8, '0);
      check(rd_data[7:0], exp_stat(8'h01 << (7 - i)), "event cause");
      apb(1'h1, 4'h8, 32'h01 << (7 - i));
    end
    // every mode with both software enables, through sleep and wake
    for (int m = 3; m >= 0; m--) begin
      for (int s = 0; s < 2; s++) begin
        apb(1'h1, 4'h0, 32'h1C | m);
        apb(1'h1, 4'h4, s);
        tick(40);
        check(bo_enable, exp_bo(m, s, 1'h0), "awake protection");
        @(posedge sys_clk);
        sleep_req <= 1'h1;
        @(posedge sys_clk);
        sleep_req <= 1'h0;
        tick(40);
        check({core_run, bo_enable}, {1'h0, exp_bo(m, s, 1'h1)}, "asleep");
        @(posedge sys_clk);
        wake_req <= 1'h1;
        @(posedge sys_clk);
        wake_req <= 1'h0;
        wait_run(cnt);
        if (m == 2)
          check({brownout_ready, cnt >= RDY}, 2'h3, "wake delay");
        else
          check(cnt <= 6, 1'h1, "wake not immediate");
      end
    end
    // power-on with timer, pin held past the timer
    apb(1'h1, 4'h0, 32'h17);
    vdd_mv <= 16'h03E8;
    pin_n  <= 1'h0;
    tick(40);
    check(core_reset, 1'h1, "held while supply low");
    vdd_mv <= 16'h0CE4;
    tick(POWERUP_DELAY_TIMER + 40);
    check(core_reset, 1'h1, "held while pin low");
    @(posedge sys_clk);
    pin_n <= 1'h1;
    wait_rst(1'h0, cnt);
    check(cnt >= 10 && cnt <= 18, 1'h1, "pin release delay");
    // timer alone stretches the reset
    vdd_mv <= 16'h03E8;
    tick(10);
    vdd_mv <= 16'h0CE4;
    wait_rst(1'h0, cnt);
    check(cnt >= POWERUP_DELAY_TIMER && cnt <= POWERUP_DELAY_TIMER + 25, 1'h1, "timer length");
    apb(1'h0, 4'h8, '0);
    check(rd_data[0], 1'h0, "power-on cause");
    complete_run();
  end
endmodule
